// *** dbgcr_pkg.sv ***
// constants shared by both ends of the debug command link
// assumes both ends run on the same 25 MHz system clock rate
package dbgcr_pkg;
    // device register addresses on the link
    localparam logic [7:0] ADDR_WRITE_DATA_U = 8'h13;
    localparam logic [7:0] ADDR_WRITE_DATA_H = 8'h14;
    localparam logic [7:0] ADDR_WRITE_DATA_L = 8'h15;
    localparam logic [7:0] ADDR_CPU_COMMAND = 8'h16;
    localparam logic [7:0] ADDR_BUS_GRANT_CONTROL = 8'h17;
    localparam logic [7:0] ADDR_INJECT_BYTE_4 = 8'h21;
    localparam logic [7:0] ADDR_INJECT_BYTE_3 = 8'h22;
    localparam logic [7:0] ADDR_INJECT_BYTE_2 = 8'h23;
    localparam logic [7:0] ADDR_INJECT_BYTE_1 = 8'h24;
    localparam logic [7:0] ADDR_INJECT_BYTE_0_GO = 8'h25;
    localparam logic [7:0] ADDR_MEMORY_STREAM_WRITE = 8'h30;
    // cpu command codes
    localparam logic [7:0] CMD_READ_PC = 8'h07;
    localparam logic [7:0] CMD_SET_LONG = 8'h08;
    localparam logic [7:0] CMD_CLEAR_LONG = 8'h09;
    localparam logic [7:0] CMD_EXCHANGE = 8'h0a;
    localparam logic [7:0] CMD_READ_MEM = 8'h0b;
    localparam logic [7:0] CMD_WRITE_PC = 8'h87;
    localparam logic [7:0] CMD_RESERVED_89 = 8'h89;
    localparam logic [7:0] CMD_RESERVED_8A = 8'h8a;
    localparam logic [7:0] CMD_WRITE_MEM = 8'h8b;
    // bus grant control fields
    localparam int BIT_BUS_GRANT_ENABLE = 7;
    localparam int BIT_FORCE_BUS_GRANT = 6;
    localparam logic [7:0] BUS_GRANT_CONTROL_RESET = 8'h00;
    // link timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int LINK_PERIOD_NS = 320;
    localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [2:0] LINK_LAST_BIT = 3'h7;
    // host control registers on axi4-lite
    localparam int HOST_AXI_ADDR_W = 4;
    localparam logic [3:0] HOST_ADDR_OFS = 4'h0;
    localparam logic [3:0] HOST_DATA_OFS = 4'h4;
    localparam logic [3:0] HOST_STATUS_OFS = 4'h8;
    localparam int HOST_BIT_LAST = 8;
    localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

    // memory address seen by a debug memory access
    function automatic logic [23:0] dbgcr_mem_addr(input logic long_mode,
                                                   input logic [7:0] base,
                                                   input logic [23:0] pc);
        return long_mode ? pc : {base, pc[15:0]};
    endfunction : dbgcr_mem_addr
endpackage : dbgcr_pkg

// *** dbgcr_link_if.sv ***
// serial debug link between debug master and device
// assumes the master alone drives all three wires
`timescale 1ns/1ps
interface dbgcr_link_if;
    logic lnk_clk;
    logic lnk_frame_n;
    logic lnk_data;
    modport host (output lnk_clk, output lnk_frame_n, output lnk_data);
    modport device (input lnk_clk, input lnk_frame_n, input lnk_data);
endinterface : dbgcr_link_if

// *** dbgcr_device.sv ***
// device end: write-only debug command registers of the cpu debug port
// assumes a halted cpu behind the memory and inject ports, same clock
// What this block does
// - command 09 clears long address mode
// - command 0A swaps primary and alternate registers
// - command 0B reads memory at pc, increments
// - command 8B writes low data byte, increments pc
// - master exchanges banks before reading alternates
// - master writes bus control only in break
// - enable clear: bus requests ignored, grant only by force bit
// - enable set: grant after current operation ends
// - force bit grants buses; clearing returns them
// - byte 0 write runs one instruction, stops
// - bytes fetched 0 first, then 1 to 4
// - master loads needed bytes, six-byte instructions impossible
// - inject bytes 4..0 at ascending addresses 21h-25h
// - stream byte goes to mode dependent address
// - pc increments after each streamed byte
// - stream address never auto-increments
// - command write starts operation at once
// - reads fill result, writes use data registers
`timescale 1ns/1ps
module dbgcr_device (
    // system
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // debug link
    dbgcr_link_if.device lnk,
    // cpu state
    input wire logic [7:0] i_MEMORY_BASE,
    output logic o_LONG_ADDRESS_MODE,
    output logic [23:0] o_PC,
    output logic o_REGISTER_EXCHANGE,
    output logic [23:0] o_READ_RESULT,
    output logic o_BUSY,
    // memory access
    output logic o_MEM_REQ,
    output logic o_MEM_WE,
    output logic [23:0] o_MEM_ADDR,
    output logic [7:0] o_MEM_WDATA,
    input wire logic i_MEM_ACK,
    input wire logic [7:0] i_MEM_RDATA,
    // instruction injection
    output logic o_INJECT_GO,
    output logic [39:0] o_INJECT_BYTES,
    input wire logic i_INJECT_DONE,
    // external bus sharing
    input wire logic i_EXT_BUS_REQUEST,
    output logic o_EXT_BUS_GRANT
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MEM_RD,
        ST_MEM_WR,
        ST_INJECT
    } dbgcr_dev_st_t;

    typedef struct packed {
        logic [2:0] lclk;
        logic [1:0] frm;
        logic [1:0] dat;
        logic [1:0] req;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic have_addr;
        logic [7:0] reg_addr;
        logic [7:0] wr_u;
        logic [7:0] wr_h;
        logic [7:0] wr_l;
        logic [4:0][7:0] inj;
        logic grant_en;
        logic force_grant;
        logic grant;
        logic long_mode;
        logic [23:0] pc;
        logic [23:0] rd;
        dbgcr_dev_st_t st;
        logic [7:0] mem_wdata;
        logic exch;
        logic go;
    } dbgcr_dev_state_t;

    dbgcr_dev_state_t r;
    dbgcr_dev_state_t next_r;

    always_comb begin
        logic [7:0] byte_in;
        byte_in = {r.shift[6:0], r.dat[1]};
        next_r = r;
        next_r.exch = 1'b0;
        next_r.go = 1'b0;
        // first stages feed only the second stages
        next_r.lclk = {r.lclk[1:0], lnk.lnk_clk};
        next_r.frm = {r.frm[0], lnk.lnk_frame_n};
        next_r.dat = {r.dat[0], lnk.lnk_data};
        next_r.req = {r.req[0], i_EXT_BUS_REQUEST};

        if (r.frm[1]) begin
            // frame closed: next byte of a new frame is an address
            next_r.bit_cnt = 3'h0;
            next_r.have_addr = 1'b0;
        end else if (r.lclk[1] && !r.lclk[2]) begin
            next_r.shift = byte_in;
            next_r.bit_cnt = r.bit_cnt + 3'h1;
            if (r.bit_cnt == dbgcr_pkg::LINK_LAST_BIT) begin
                if (!r.have_addr) begin
                    next_r.reg_addr = byte_in;
                    next_r.have_addr = 1'b1;
                end else begin
                    unique case (r.reg_addr)
                        dbgcr_pkg::ADDR_WRITE_DATA_U: begin
                            next_r.wr_u = byte_in;
                        end
                        dbgcr_pkg::ADDR_WRITE_DATA_H: begin
                            next_r.wr_h = byte_in;
                        end
                        dbgcr_pkg::ADDR_WRITE_DATA_L: begin
                            next_r.wr_l = byte_in;
                        end
                        dbgcr_pkg::ADDR_CPU_COMMAND: begin
                            // commands while busy are dropped, the master polls busy
                            if (r.st == ST_IDLE) begin
                                unique case (byte_in)
                                    dbgcr_pkg::CMD_READ_PC: begin
                                        next_r.rd = r.pc;
                                    end
                                    dbgcr_pkg::CMD_SET_LONG: begin
                                        next_r.long_mode = 1'b1;
                                    end
                                    dbgcr_pkg::CMD_CLEAR_LONG: begin
                                        next_r.long_mode = 1'b0;
                                    end
                                    dbgcr_pkg::CMD_EXCHANGE: begin
                                        next_r.exch = 1'b1;
                                    end
                                    dbgcr_pkg::CMD_READ_MEM: begin
                                        next_r.st = ST_MEM_RD;
                                    end
                                    dbgcr_pkg::CMD_WRITE_PC: begin
                                        next_r.pc = {r.wr_u, r.wr_h, r.wr_l};
                                    end
                                    dbgcr_pkg::CMD_WRITE_MEM: begin
                                        next_r.st = ST_MEM_WR;
                                        next_r.mem_wdata = r.wr_l;
                                    end
                                    dbgcr_pkg::CMD_RESERVED_89,
                                    dbgcr_pkg::CMD_RESERVED_8A: begin
                                        next_r.st = r.st;
                                    end
                                    default: begin
                                        next_r.st = r.st;
                                    end
                                endcase
                            end
                        end
                        dbgcr_pkg::ADDR_BUS_GRANT_CONTROL: begin
                            next_r.grant_en = byte_in[dbgcr_pkg::BIT_BUS_GRANT_ENABLE];
                            next_r.force_grant = byte_in[dbgcr_pkg::BIT_FORCE_BUS_GRANT];
                        end
                        dbgcr_pkg::ADDR_INJECT_BYTE_4: begin
                            next_r.inj[4] = byte_in;
                        end
                        dbgcr_pkg::ADDR_INJECT_BYTE_3: begin
                            next_r.inj[3] = byte_in;
                        end
                        dbgcr_pkg::ADDR_INJECT_BYTE_2: begin
                            next_r.inj[2] = byte_in;
                        end
                        dbgcr_pkg::ADDR_INJECT_BYTE_1: begin
                            next_r.inj[1] = byte_in;
                        end
                        dbgcr_pkg::ADDR_INJECT_BYTE_0_GO: begin
                            next_r.inj[0] = byte_in;
                            if (r.st == ST_IDLE) begin
                                next_r.st = ST_INJECT;
                                next_r.go = 1'b1;
                            end
                        end
                        dbgcr_pkg::ADDR_MEMORY_STREAM_WRITE: begin
                            if (r.st == ST_IDLE) begin
                                next_r.st = ST_MEM_WR;
                                next_r.mem_wdata = byte_in;
                            end
                        end
                        default: begin
                            next_r.st = r.st;
                        end
                    endcase
                    // streaming target keeps its address
                    if (r.reg_addr != dbgcr_pkg::ADDR_MEMORY_STREAM_WRITE) begin
                        next_r.reg_addr = r.reg_addr + 8'h01;
                    end
                end
            end
        end

        // operations in flight
        unique case (r.st)
            ST_IDLE: begin
                next_r.st = next_r.st;
            end
            ST_MEM_RD, ST_MEM_WR: begin
                if (i_MEM_ACK && !r.grant) begin
                    if (r.st == ST_MEM_RD) begin
                        next_r.rd = {16'h0000, i_MEM_RDATA};
                    end
                    next_r.pc = r.pc + 24'h000001;
                    next_r.st = ST_IDLE;
                end
            end
            ST_INJECT: begin
                // cpu stopped again after its single instruction
                if (i_INJECT_DONE) begin
                    next_r.st = ST_IDLE;
                end
            end
        endcase

        // request grant waits for idle; force overrides everything
        next_r.grant = r.force_grant
            | (r.grant_en & r.req[1] & (r.st == ST_IDLE));
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            r <= '0;
        end else if (I_CE) begin
            r <= next_r;
        end
    end

    // outputs
    assign o_LONG_ADDRESS_MODE = r.long_mode;
    assign o_PC = r.pc;
    assign o_REGISTER_EXCHANGE = r.exch;
    assign o_READ_RESULT = r.rd;
    assign o_BUSY = (r.st != ST_IDLE);
    // memory access pauses while the buses are given away
    assign o_MEM_REQ = ((r.st == ST_MEM_RD) || (r.st == ST_MEM_WR)) && !r.grant;
    assign o_MEM_WE = (r.st == ST_MEM_WR);
    assign o_MEM_ADDR = dbgcr_pkg::dbgcr_mem_addr(r.long_mode, i_MEMORY_BASE, r.pc);
    assign o_MEM_WDATA = r.mem_wdata;
    assign o_INJECT_GO = r.go;
    // byte 0 in the low lane is fetched first
    assign o_INJECT_BYTES = r.inj;
    assign o_EXT_BUS_GRANT = r.grant;

endmodule : dbgcr_device

// *** dbgcr_host.sv ***
// host end: debug master driving the serial link, ordered over axi4-lite
// assumes one axi4-lite master on the same clock
`timescale 1ns/1ps
module dbgcr_host #(
    parameter int HALF_CYCLES = dbgcr_pkg::LINK_HALF_CYCLES
) (
    // system
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // axi4-lite write
    input wire logic [dbgcr_pkg::HOST_AXI_ADDR_W-1:0] i_AWADDR,
    input wire logic i_AWVALID,
    output logic o_AWREADY,
    input wire logic [31:0] i_WDATA,
    input wire logic [3:0] i_WSTRB,
    input wire logic i_WVALID,
    output logic o_WREADY,
    output logic [1:0] o_BRESP,
    output logic o_BVALID,
    input wire logic i_BREADY,
    // axi4-lite read
    input wire logic [dbgcr_pkg::HOST_AXI_ADDR_W-1:0] i_ARADDR,
    input wire logic i_ARVALID,
    output logic o_ARREADY,
    output logic [31:0] o_RDATA,
    output logic [1:0] o_RRESP,
    output logic o_RVALID,
    input wire logic i_RREADY,
    // debug link
    dbgcr_link_if.host lnk
);

    if (HALF_CYCLES < 1 || HALF_CYCLES > 255) begin : g_bad_half
        $error("HALF_CYCLES must lie in 1..255");
    end

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_LOW,
        TX_HIGH
    } dbgcr_tx_st_t;

    typedef struct packed {
        logic aw_full;
        logic [3:0] aw_addr;
        logic w_full;
        logic [8:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [7:0] dev_addr;
        logic pend;
        logic [7:0] pend_byte;
        logic pend_last;
        dbgcr_tx_st_t tx;
        logic in_frame;
        logic send_addr;
        logic cur_last;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [7:0] div;
        logic lclk;
        logic frame_n;
        logic ldata;
    } dbgcr_host_state_t;

    localparam logic [7:0] DIV_LAST = 8'(HALF_CYCLES - 1);

    dbgcr_host_state_t r;
    dbgcr_host_state_t next_r;
    logic busy;

    assign busy = r.pend || r.in_frame || (r.tx != TX_IDLE);

    always_comb begin
        next_r = r;
        // link transmitter, data changes with the falling clock
        unique case (r.tx)
            TX_IDLE: begin
                if (r.pend) begin
                    if (!r.in_frame) begin
                        next_r.frame_n = 1'b0;
                        next_r.in_frame = 1'b1;
                        next_r.send_addr = 1'b1;
                        next_r.shift = r.dev_addr;
                    end else begin
                        next_r.shift = r.pend_byte;
                        next_r.cur_last = r.pend_last;
                        next_r.pend = 1'b0;
                    end
                    next_r.tx = TX_LOW;
                    next_r.div = 8'h00;
                    next_r.bit_cnt = 3'h0;
                    next_r.lclk = 1'b0;
                    next_r.ldata = next_r.shift[7];
                end
            end
            TX_LOW: begin
                if (r.div == DIV_LAST) begin
                    next_r.div = 8'h00;
                    next_r.lclk = 1'b1;
                    next_r.tx = TX_HIGH;
                end else begin
                    next_r.div = r.div + 8'h01;
                end
            end
            TX_HIGH: begin
                if (r.div == DIV_LAST) begin
                    next_r.div = 8'h00;
                    next_r.shift = {r.shift[6:0], 1'b0};
                    next_r.bit_cnt = r.bit_cnt + 3'h1;
                    if (r.bit_cnt == dbgcr_pkg::LINK_LAST_BIT) begin
                        next_r.tx = TX_IDLE;
                        if (r.send_addr) begin
                            next_r.send_addr = 1'b0;
                        end else if (r.cur_last) begin
                            next_r.frame_n = 1'b1;
                            next_r.in_frame = 1'b0;
                        end
                    end else begin
                        next_r.lclk = 1'b0;
                        next_r.ldata = r.shift[6];
                        next_r.tx = TX_LOW;
                    end
                end else begin
                    next_r.div = r.div + 8'h01;
                end
            end
            default: begin
                next_r.tx = TX_IDLE;
            end
        endcase

        // axi4-lite write side
        if (i_AWVALID && !r.aw_full) begin
            next_r.aw_full = 1'b1;
            next_r.aw_addr = i_AWADDR;
        end
        if (i_WVALID && !r.w_full) begin
            next_r.w_full = 1'b1;
            next_r.w_data = i_WDATA[dbgcr_pkg::HOST_BIT_LAST:0];
            next_r.w_lane0 = i_WSTRB[0];
        end
        if (r.bvalid && i_BREADY) begin
            next_r.bvalid = 1'b0;
        end
        // a data byte waits while one is still queued: back-pressure
        if (r.aw_full && r.w_full && !r.bvalid
            && !(r.aw_addr == dbgcr_pkg::HOST_DATA_OFS && r.pend)) begin
            next_r.aw_full = 1'b0;
            next_r.w_full = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = dbgcr_pkg::AXI_RESP_OKAY;
            unique case (r.aw_addr)
                dbgcr_pkg::HOST_ADDR_OFS: begin
                    if (r.w_lane0) begin
                        next_r.dev_addr = r.w_data[7:0];
                    end
                end
                dbgcr_pkg::HOST_DATA_OFS: begin
                    if (r.w_lane0) begin
                        next_r.pend = 1'b1;
                        next_r.pend_byte = r.w_data[7:0];
                        next_r.pend_last = r.w_data[dbgcr_pkg::HOST_BIT_LAST];
                    end
                end
                dbgcr_pkg::HOST_STATUS_OFS: begin
                    next_r.bresp = dbgcr_pkg::AXI_RESP_OKAY;
                end
                default: begin
                    next_r.bresp = dbgcr_pkg::AXI_RESP_SLVERR;
                end
            endcase
        end

        // axi4-lite read side
        if (r.rvalid && i_RREADY) begin
            next_r.rvalid = 1'b0;
        end
        if (i_ARVALID && !r.rvalid) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = dbgcr_pkg::AXI_RESP_OKAY;
            unique case (i_ARADDR)
                dbgcr_pkg::HOST_ADDR_OFS: begin
                    next_r.rdata = r.dev_addr;
                end
                dbgcr_pkg::HOST_DATA_OFS: begin
                    next_r.rdata = 8'h00;
                end
                dbgcr_pkg::HOST_STATUS_OFS: begin
                    next_r.rdata = {6'h00, r.pend, busy};
                end
                default: begin
                    next_r.rdata = 8'h00;
                    next_r.rresp = dbgcr_pkg::AXI_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            r <= '0;
            r.lclk <= 1'b1;
            r.frame_n <= 1'b1;
        end else if (I_CE) begin
            r <= next_r;
        end
    end

    // outputs
    assign o_AWREADY = !r.aw_full;
    assign o_WREADY = !r.w_full;
    assign o_BVALID = r.bvalid;
    assign o_BRESP = r.bresp;
    assign o_ARREADY = !r.rvalid;
    assign o_RVALID = r.rvalid;
    assign o_RRESP = r.rresp;
    assign o_RDATA = {24'h000000, r.rdata};
    assign lnk.lnk_clk = r.lclk;
    assign lnk.lnk_frame_n = r.frame_n;
    assign lnk.lnk_data = r.ldata;

endmodule : dbgcr_host

// *** dbgcr_checker.sv ***
// checker on the link wires and the device's handshakes
// assumes host half period of one clock and the bench memory stand-in
`timescale 1ns/1ps
module dbgcr_checker (
    // system and link
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic lnk_clk,
    input wire logic lnk_frame_n,
    input wire logic lnk_data,
    // device
    input wire logic o_MEM_REQ,
    input wire logic i_MEM_ACK,
    input wire logic [23:0] o_PC,
    input wire logic o_INJECT_GO,
    input wire logic o_BUSY,
    input wire logic o_REGISTER_EXCHANGE,
    input wire logic o_EXT_BUS_GRANT
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // one cycle go, then go low and busy in the cycle after it
    sequence s_go;
        o_INJECT_GO ##1 (!o_INJECT_GO && o_BUSY);
    endsequence
    idle_clock_a: assert property (lnk_frame_n |-> lnk_clk)
        else $error("link clock low outside frame");
    frame_open_a: assert property ($fell(lnk_frame_n) |-> !lnk_clk)
        else $error("frame opened with clock high");
    data_hold_a: assert property (lnk_clk && $past(lnk_clk) && !lnk_frame_n |-> $stable(lnk_data))
        else $error("link data moved while clock high");
    go_pulse_a: assert property (o_INJECT_GO |-> s_go)
        else $error("inject go not one pulse with busy");
    exch_pulse_a: assert property (o_REGISTER_EXCHANGE |=> !o_REGISTER_EXCHANGE)
        else $error("exchange pulse too long");
    pc_step_a: assert property (o_MEM_REQ && i_MEM_ACK |=>
        !o_MEM_REQ && o_PC == $past(o_PC) + 24'h1) else $error("pc not stepped");
    req_hold_a: assert property (o_MEM_REQ && !i_MEM_ACK && !o_EXT_BUS_GRANT |=> o_MEM_REQ)
        else $error("memory request dropped early");
    grant_free_a: assert property (o_EXT_BUS_GRANT |-> !o_MEM_REQ)
        else $error("memory access while bus granted");
endmodule : dbgcr_checker

// *** debug_cpu_command_registers_tb.sv ***
// bench: host and device ends joined by the link, orders over axi4-lite
// assumes memory and cpu stand-ins answer within a cycle
`timescale 1ns/1ps
module debug_cpu_command_registers_tb;
    localparam logic [1:0] OK = dbgcr_pkg::AXI_RESP_OKAY;
    logic clk, rst, ack, done, brq, awv, wv, br, arv, rr, rp, lng;
    logic [3:0] awa, ara;
    logic [31:0] wd, rd;
    logic [7:0] mb, rdat, mwd;
    logic [23:0] pc, pco, res, ma;
    logic [47:0] e;
    logic [7:0] bq[$];
    logic [47:0] q[$];
    logic [9:0] bt[5] = '{10'h100, 10'h380, 10'h080, 10'h240, 10'h000};
    logic [7:0] cm[3] = '{dbgcr_pkg::CMD_RESERVED_89, dbgcr_pkg::CMD_RESERVED_8A,
        dbgcr_pkg::CMD_EXCHANGE};
    int failures, cmp_count;
    logic lm, xch, busy, mrq, mwe, go, gnt, awr, wrd, bv, arr, rv;
    logic [39:0] ib;
    logic [1:0] brs;
    dbgcr_link_if dbgcr_link_if_i ();
    dbgcr_device dbgcr_device_i (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .lnk(dbgcr_link_if_i),
        .i_MEMORY_BASE(mb), .o_LONG_ADDRESS_MODE(lm), .o_PC(pco), .o_REGISTER_EXCHANGE(xch),
        .o_READ_RESULT(res), .o_BUSY(busy), .o_MEM_REQ(mrq), .o_MEM_WE(mwe), .o_MEM_ADDR(ma),
        .o_MEM_WDATA(mwd), .i_MEM_ACK(ack), .i_MEM_RDATA(rdat), .o_INJECT_GO(go),
        .o_INJECT_BYTES(ib), .i_INJECT_DONE(done), .i_EXT_BUS_REQUEST(brq),
        .o_EXT_BUS_GRANT(gnt));
    dbgcr_host #(.HALF_CYCLES(1)) dbgcr_host_i (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1),
        .i_AWADDR(awa), .i_AWVALID(awv), .o_AWREADY(awr), .i_WDATA(wd), .i_WSTRB(4'hf),
        .i_WVALID(wv), .o_WREADY(wrd), .o_BRESP(brs), .o_BVALID(bv), .i_BREADY(br),
        .i_ARADDR(ara), .i_ARVALID(arv), .o_ARREADY(arr), .o_RDATA(rd), .o_RRESP(),
        .o_RVALID(rv), .i_RREADY(rr), .lnk(dbgcr_link_if_i));
    dbgcr_checker dbgcr_checker_i (.I_CLK(clk), .I_RST(rst), .lnk_clk(dbgcr_link_if_i.lnk_clk),
        .lnk_frame_n(dbgcr_link_if_i.lnk_frame_n), .lnk_data(dbgcr_link_if_i.lnk_data),
        .o_MEM_REQ(mrq), .i_MEM_ACK(ack), .o_PC(pco), .o_INJECT_GO(go), .o_BUSY(busy),
        .o_REGISTER_EXCHANGE(xch), .o_EXT_BUS_GRANT(gnt));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // read data follows the address, so reads can be predicted
    always @(posedge clk) begin
        ack <= mrq && !ack && !rst;
        rdat <= ma[7:0] ^ 8'h5a;
        done <= go;
        rp <= mrq && ack && !mwe;
        if (mrq && ack && mwe) got({8'h01, ma, mwd});
        if (go) got({8'h02, ib});
        if (xch) got(48'h03_0000000000);
        if (rp) got({8'h04, 16'h0, res});
    end
    task chk(input logic [47:0] s, input logic [47:0] x);
        cmp_count++;
        if (s !== x) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task got(input logic [47:0] v);
        chk(v, q.size() > 0 ? q.pop_front() : 48'hx);
    endtask : got
    task results;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    function automatic logic [47:0] ex(input logic [7:0] d);
        ex = {8'h01, lng ? pc : {mb, pc[15:0]}, d};
        pc = pc + 24'h1;
    endfunction : ex
    task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, b;
        logic [1:0] s;
        @(posedge clk);
        {awa, wd, awv, wv, br} <= {a, d, 3'h7};
        do begin
            @(negedge clk);
            {ta, tw, b, s} = {awv & ~awr, wv & ~wrd, bv, brs};
            @(posedge clk);
            {awv, wv} <= {ta, tw};
        end while (!b);
        br <= 1'b0;
        chk({46'h0, s}, {46'h0, r});
    endtask : axw
    task axr(input logic [3:0] a, output logic [31:0] d);
        logic t, v;
        @(posedge clk);
        {ara, arv, rr} <= {a, 2'h3};
        do begin
            @(negedge clk);
            {t, v, d} = {arv & ~arr, rv, rd};
            @(posedge clk);
            arv <= t;
        end while (!v);
        rr <= 1'b0;
    endtask : axr
    // one frame of bq, then wait for the host and device to go quiet
    task fr(input logic [7:0] a);
        logic [31:0] s;
        axw(4'h0, {24'h0, a}, OK);
        foreach (bq[i]) axw(4'h4, {23'h0, i == bq.size() - 1, bq[i]}, OK);
        s = 32'h1;
        while (s !== 32'h0) axr(4'h8, s);
        repeat (8) @(posedge clk);
        while (busy !== 1'b0) @(posedge clk);
    endtask : fr
    // generous: a frame byte takes about 17 cycles at the one-clock half period
    initial begin
        #2000000;
        failures++;
        results();
    end
    initial begin
        {rst, ack, done, brq, awv, wv, br, arv, rr, rp, lng} = 11'h400;
        {awa, ara, wd, rdat} = 48'h0;
        void'($urandom(32'he857f358));
        mb = 8'($urandom);
        pc = 24'($urandom);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bq = {pc[23:16], pc[15:8], pc[7:0], dbgcr_pkg::CMD_WRITE_PC};
        fr(dbgcr_pkg::ADDR_WRITE_DATA_U);
        chk({24'h0, pco}, {24'h0, pc});
        for (int k = 0; k < 2; k++) begin
            bq = {k == 0 ? dbgcr_pkg::CMD_SET_LONG : dbgcr_pkg::CMD_CLEAR_LONG};
            lng = (k == 0);
            fr(dbgcr_pkg::ADDR_CPU_COMMAND);
            chk({47'h0, lm}, {47'h0, lng});
            bq = {};
            repeat (3) bq.push_back(8'($urandom));
            foreach (bq[i]) q.push_back(ex(bq[i]));
            fr(dbgcr_pkg::ADDR_MEMORY_STREAM_WRITE);
            $display("test stream %0d done", k);
        end
        e = ex(8'h0);
        q.push_back({8'h04, 32'h0, e[15:8] ^ 8'h5a});
        bq = {dbgcr_pkg::CMD_READ_MEM};
        fr(dbgcr_pkg::ADDR_CPU_COMMAND);
        bq = {8'($urandom), dbgcr_pkg::CMD_WRITE_MEM};
        q.push_back(ex(bq[0]));
        fr(dbgcr_pkg::ADDR_WRITE_DATA_L);
        for (int k = 0; k < 3; k++) begin
            bq = {cm[k]};
            if (k == 2) q.push_back(48'h03_0000000000);
            fr(dbgcr_pkg::ADDR_CPU_COMMAND);
            chk({23'h0, lm, pco}, {24'h0, pc});
        end
        $display("test commands done");
        bq = {};
        repeat (5) bq.push_back(8'($urandom));
        q.push_back({8'h02, bq[0], bq[1], bq[2], bq[3], bq[4]});
        fr(dbgcr_pkg::ADDR_INJECT_BYTE_4);
        $display("test inject done");
        for (int k = 0; k < 5; k++) begin
            brq <= bt[k][8];
            bq = {bt[k][7:0]};
            fr(dbgcr_pkg::ADDR_BUS_GRANT_CONTROL);
            repeat (4) @(posedge clk);
            chk({47'h0, gnt}, {47'h0, bt[k][9]});
        end
        axw(4'hc, 32'h0, dbgcr_pkg::AXI_RESP_SLVERR);
        chk({47'h0, q.size() == 0}, 48'h1);
        $display("test bus grant done");
        results();
    end
endmodule : debug_cpu_command_registers_tb
